// ===== inc/iprc_consts.svh
// constants for the interrupt priority register block
// assumes: included by bare name from package and design files
`ifndef IPRC_CONSTS_SVH
`define IPRC_CONSTS_SVH

// register indices; the map steps by two, so each index gets a whole word
`define IPRC_IDX_PIN_CHANGE   12'h0B0
`define IPRC_IDX_CMP_1_3      12'h0B2
`define IPRC_IDX_CMP_4        12'h0B4
`define IPRC_IDX_ADC_0_2      12'h0B6
`define IPRC_IDX_ADC_3_5      12'h0B8

// register byte offsets on the apb bus, four times the index
`define IPRC_OFS_PIN_CHANGE   12'h2C0
`define IPRC_OFS_CMP_1_3      12'h2C8
`define IPRC_OFS_CMP_4        12'h2D0
`define IPRC_OFS_ADC_0_2      12'h2D8
`define IPRC_OFS_ADC_3_5      12'h2E0

// register reset words: every implemented field at level 4
`define IPRC_RST_PIN_CHANGE   16'h4000
`define IPRC_RST_CMP_1_3      16'h4440
`define IPRC_RST_CMP_4        16'h0004
`define IPRC_RST_ADC_0_2      16'h4440
`define IPRC_RST_ADC_3_5      16'h0444

// field low bit positions
`define IPRC_POS_HI           12
`define IPRC_POS_MID          8
`define IPRC_POS_LO           4
`define IPRC_POS_BOT          0

// field reset value: msb set, lower bits clear
`define IPRC_LEVEL_RST        3'h4
`define IPRC_LEVEL_OFF        3'h0

// implemented-bit masks per register
`define IPRC_MASK_PIN_CHANGE  16'h7000
`define IPRC_MASK_CMP_1_3     16'h7770
`define IPRC_MASK_CMP_4       16'h0007
`define IPRC_MASK_ADC_0_2     16'h7770
`define IPRC_MASK_ADC_3_5     16'h0777

`endif

// ===== inc/iprc_pkg.sv
// types for the interrupt priority register block
// assumes: iprc_consts.svh is on the include path
package iprc_pkg;
  `include "iprc_consts.svh"

  typedef logic [2:0] iprc_level_t;

  // every source level as seen by the arbiter
  typedef struct packed {
    iprc_level_t pin_change_level;
    iprc_level_t comparator_one_level;
    iprc_level_t comparator_two_level;
    iprc_level_t comparator_three_level;
    iprc_level_t comparator_four_level;
    iprc_level_t adc_pair_zero_level;
    iprc_level_t adc_pair_one_level;
    iprc_level_t adc_pair_two_level;
    iprc_level_t adc_pair_three_level;
    iprc_level_t adc_pair_four_level;
    iprc_level_t adc_pair_five_level;
  } iprc_levels_t;

  // per-source decoded view
  typedef struct packed {
    logic        enabled;
    iprc_level_t level;
  } iprc_grant_t;
endpackage : iprc_pkg

// ===== hdl/iprc_level_dec.sv
// one source's level decode for the arbiter
// assumes: code comes straight from a priority field register
`timescale 1ns/1ps
`include "iprc_consts.svh"
module iprc_level_dec
  import iprc_pkg::*;
(
  input  wire iprc_level_t code,
  output iprc_grant_t      grant
);
  // code 0 disables; 1..7 map one-to-one onto levels 1..7
  always_comb begin
    grant.enabled = (code != `IPRC_LEVEL_OFF);
    grant.level   = code;
  end
endmodule : iprc_level_dec

// ===== hdl/iprc_regs.sv
// apb register file holding interrupt priority fields
// assumes: apb master on clk, arbiter consumes levels and enables
`timescale 1ns/1ps
`include "iprc_consts.svh"
module iprc_regs
  import iprc_pkg::*;
#(
  parameter int NSRC = 11
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output iprc_levels_t       levels,
  output logic [NSRC-1:0]    src_enabled
);

  logic [15:0] pin_q, cmp13_q, cmp4_q, adc02_q, adc35_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        hit;
  logic [15:0] rd_word;
  logic [15:0] wmask;
  logic        acc_wr;
  logic        wr_pin, wr_cmp13, wr_cmp4, wr_adc02, wr_adc35;

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign acc_wr  = psel && penable && pwrite;
  assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // one write strobe per register, only in the access phase
  assign wr_pin   = acc_wr && (paddr == `IPRC_OFS_PIN_CHANGE);
  assign wr_cmp13 = acc_wr && (paddr == `IPRC_OFS_CMP_1_3);
  assign wr_cmp4  = acc_wr && (paddr == `IPRC_OFS_CMP_4);
  assign wr_adc02 = acc_wr && (paddr == `IPRC_OFS_ADC_0_2);
  assign wr_adc35 = acc_wr && (paddr == `IPRC_OFS_ADC_3_5);

  // address decode and masked read word
  always_comb begin
    hit     = 1'b1;
    rd_word = 16'h0000;
    case (paddr)
      `IPRC_OFS_PIN_CHANGE: rd_word = pin_q & `IPRC_MASK_PIN_CHANGE;
      `IPRC_OFS_CMP_1_3:    rd_word = cmp13_q & `IPRC_MASK_CMP_1_3;
      `IPRC_OFS_CMP_4:      rd_word = cmp4_q & `IPRC_MASK_CMP_4;
      `IPRC_OFS_ADC_0_2:    rd_word = adc02_q & `IPRC_MASK_ADC_0_2;
      `IPRC_OFS_ADC_3_5:    rd_word = adc35_q & `IPRC_MASK_ADC_3_5;
      default:              hit = 1'b0;
    endcase
  end

  // merge a write into one register keeping only implemented bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] impl);
    logic [15:0] m;
    m = wmask & impl;
    merge = (old & ~m) | (pwdata[15:0] & m);
  endfunction : merge

  // change notify field; one process per register keeps its reset word beside it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_q <= `IPRC_RST_PIN_CHANGE;
    end else if (wr_pin) begin
      pin_q <= merge(pin_q, `IPRC_MASK_PIN_CHANGE);
    end
  end

  // comparator 1 to 3 fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp13_q <= `IPRC_RST_CMP_1_3;
    end else if (wr_cmp13) begin
      cmp13_q <= merge(cmp13_q, `IPRC_MASK_CMP_1_3);
    end
  end

  // comparator 4 field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp4_q <= `IPRC_RST_CMP_4;
    end else if (wr_cmp4) begin
      cmp4_q <= merge(cmp4_q, `IPRC_MASK_CMP_4);
    end
  end

  // adc pair 0 to 2 fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc02_q <= `IPRC_RST_ADC_0_2;
    end else if (wr_adc02) begin
      adc02_q <= merge(adc02_q, `IPRC_MASK_ADC_0_2);
    end
  end

  // adc pair 3 to 5 fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc35_q <= `IPRC_RST_ADC_3_5;
    end else if (wr_adc35) begin
      adc35_q <= merge(adc35_q, `IPRC_MASK_ADC_3_5);
    end
  end

  // read data registered in setup so it is stable in the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
      pslverr_q <= !hit; // unmapped address answers with an error
    end
  end

  // continuous level outputs straight from the fields
  always_comb begin
    levels.pin_change_level       = pin_q[`IPRC_POS_HI +: 3];
    levels.comparator_three_level = cmp13_q[`IPRC_POS_HI +: 3];
    levels.comparator_two_level   = cmp13_q[`IPRC_POS_MID +: 3];
    levels.comparator_one_level   = cmp13_q[`IPRC_POS_LO +: 3];
    levels.comparator_four_level  = cmp4_q[`IPRC_POS_BOT +: 3];
    levels.adc_pair_two_level     = adc02_q[`IPRC_POS_HI +: 3];
    levels.adc_pair_one_level     = adc02_q[`IPRC_POS_MID +: 3];
    levels.adc_pair_zero_level    = adc02_q[`IPRC_POS_LO +: 3];
    levels.adc_pair_five_level    = adc35_q[`IPRC_POS_MID +: 3];
    levels.adc_pair_four_level    = adc35_q[`IPRC_POS_LO +: 3];
    levels.adc_pair_three_level   = adc35_q[`IPRC_POS_BOT +: 3];
  end

  // per-source enable; index 10 is pin change, 0 is adc pair five
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_dec
      iprc_grant_t g;
      iprc_level_dec u_dec (
        .code  (levels[i*3 +: 3]),
        .grant (g)
      );
      assign src_enabled[i] = g.enabled;
      en_match_a: assert property (@(posedge clk) disable iff (sys_rst)
        src_enabled[i] == (levels[i*3 +: 3] != `IPRC_LEVEL_OFF))
        else $error("source enable disagrees with its level");
    end
  endgenerate

  // level 4 after reset on the pin change and adc pair three fields
  rst_level_a: assert property (@(posedge clk)
    $past(sys_rst) |-> levels.pin_change_level == 3'h4
                      && levels.adc_pair_three_level == 3'h4)
    else $error("field not at level 4 after reset");

  // disabled source never reported enabled
  off_source_a: assert property (@(posedge clk) disable iff (sys_rst)
    levels.comparator_four_level == 3'h0 |-> !src_enabled[6])
    else $error("disabled source shown enabled");

  // nonzero code enables the source
  on_source_a: assert property (@(posedge clk) disable iff (sys_rst)
    levels.pin_change_level != 3'h0 |-> src_enabled[10])
    else $error("nonzero level not enabled");

  // unimplemented bits always read zero
  zero_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_PIN_CHANGE)
      |-> prdata[11:0] == 12'h000 && prdata[15] == 1'b0)
    else $error("unused bits read nonzero");

  zero_cmp4_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_CMP_4)
      |-> prdata[15:3] == 13'h0000)
    else $error("unused comparator 4 bits nonzero");

  zero_adc35_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_ADC_3_5)
      |-> prdata[15:11] == 5'h00 && prdata[7] == 1'b0)
    else $error("unused adc 3-5 bits nonzero");

  // a full write lands on the level output one cycle later
  sequence cmp_wr_s;
    acc_wr && paddr == `IPRC_OFS_CMP_1_3 && pstrb[1:0] == 2'h3;
  endsequence
  cmp_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmp_wr_s |=> levels.comparator_two_level == $past(pwdata[10:8])
                 && levels.comparator_one_level == $past(pwdata[6:4]))
    else $error("comparator level not updated");

  sequence adc_wr_s;
    acc_wr && paddr == `IPRC_OFS_ADC_0_2 && pstrb[1];
  endsequence
  adc_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    adc_wr_s |=> levels.adc_pair_two_level == $past(pwdata[14:12]))
    else $error("adc pair two level not updated");

  // read data never carries anything above bit 15
  rd_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half nonzero");

  // comparator register gaps read zero
  zero_cmp13_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_CMP_1_3)
      |-> (prdata[15:0] & 16'h888F) == 16'h0000)
    else $error("unused comparator 1-3 bits nonzero");

  // adc 0-2 register gaps read zero
  zero_adc02_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_ADC_0_2)
      |-> (prdata[15:0] & 16'h888F) == 16'h0000)
    else $error("unused adc 0-2 bits nonzero");

  // adc 3-5 register gaps, bit 3 included, read zero
  zero_adc35_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_ADC_3_5)
      |-> (prdata[15:0] & 16'hF888) == 16'h0000)
    else $error("unused adc 3-5 low bits nonzero");

  // an unmapped place answers with an error
  bad_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !hit) |-> pslverr)
    else $error("unmapped access without error");

  // a mapped place never answers with an error
  good_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && hit) |-> !pslverr)
    else $error("mapped access with error");

  // read data agrees with what the arbiter is shown
  read_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_PIN_CHANGE)
      |-> prdata[14:12] == levels.pin_change_level)
    else $error("change notify read disagrees with level");

  read_cmp13_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_CMP_1_3)
      |-> prdata[14:12] == levels.comparator_three_level
          && prdata[10:8] == levels.comparator_two_level
          && prdata[6:4] == levels.comparator_one_level)
    else $error("comparator 1-3 read disagrees with levels");

  read_cmp4_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_CMP_4)
      |-> prdata[2:0] == levels.comparator_four_level)
    else $error("comparator 4 read disagrees with level");

  read_adc02_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_ADC_0_2)
      |-> prdata[14:12] == levels.adc_pair_two_level
          && prdata[10:8] == levels.adc_pair_one_level
          && prdata[6:4] == levels.adc_pair_zero_level)
    else $error("adc 0-2 read disagrees with levels");

  read_adc35_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && penable && !pwrite && paddr == `IPRC_OFS_ADC_3_5)
      |-> prdata[10:8] == levels.adc_pair_five_level
          && prdata[6:4] == levels.adc_pair_four_level
          && prdata[2:0] == levels.adc_pair_three_level)
    else $error("adc 3-5 read disagrees with levels");

  // a high-lane write to the change notify register lands next cycle
  sequence pin_wr_s;
    wr_pin && pstrb[1];
  endsequence
  pin_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    pin_wr_s |=> levels.pin_change_level == $past(pwdata[14:12]))
    else $error("change notify level not updated");

  // a low-lane write to comparator 4 lands next cycle
  sequence cmp4_wr_s;
    wr_cmp4 && pstrb[0];
  endsequence
  cmp4_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmp4_wr_s |=> levels.comparator_four_level == $past(pwdata[2:0]))
    else $error("comparator 4 level not updated");

  // a high-lane write reaches comparator 3
  sequence cmp_hi_wr_s;
    wr_cmp13 && pstrb[1];
  endsequence
  cmp3_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmp_hi_wr_s |=> levels.comparator_three_level == $past(pwdata[14:12]))
    else $error("comparator 3 level not updated");

  // a low-lane write reaches adc pair 0 alone
  sequence adc_lo_wr_s;
    wr_adc02 && pstrb[0];
  endsequence
  adc_zero_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    adc_lo_wr_s |=> levels.adc_pair_zero_level == $past(pwdata[6:4]))
    else $error("adc pair zero level not updated");

  adc_one_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    adc_wr_s |=> levels.adc_pair_one_level == $past(pwdata[10:8]))
    else $error("adc pair one level not updated");

  // adc pair 5 sits in the high lane of its register
  sequence adc35_hi_wr_s;
    wr_adc35 && pstrb[1];
  endsequence
  adc35_hi_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    adc35_hi_wr_s |=> levels.adc_pair_five_level == $past(pwdata[10:8]))
    else $error("adc pair five level not updated");

  // adc pairs 4 and 3 share the low lane
  sequence adc35_lo_wr_s;
    wr_adc35 && pstrb[0];
  endsequence
  adc35_lo_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    adc35_lo_wr_s |=> levels.adc_pair_four_level == $past(pwdata[6:4])
                      && levels.adc_pair_three_level == $past(pwdata[2:0]))
    else $error("adc pair four or three level not updated");

  // without a write the arbiter sees no change
  hold_levels_a: assert property (@(posedge clk) disable iff (sys_rst)
    !acc_wr |=> $stable(levels))
    else $error("levels moved without a write");

  // a write to an unmapped place is ignored
  bad_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (acc_wr && !hit) |=> $stable(levels))
    else $error("unmapped write changed a level");

  // every field, not only the first and last, at level 4 after reset
  rst_all_a: assert property (@(posedge clk)
    $past(sys_rst) |-> levels == {11{`IPRC_LEVEL_RST}})
    else $error("some field not at level 4 after reset");

  // bus outputs quiet after reset
  rst_bus_a: assert property (@(posedge clk)
    $past(sys_rst) |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("bus outputs not cleared by reset");

endmodule : iprc_regs

// ===== verif/iprc_arb_model.sv
// arbiter stand-in that consumes the priority levels
// assumes: levels and src_enabled come straight from iprc_regs
`timescale 1ns/1ps
module iprc_arb_model
  import iprc_pkg::*;
(
  input  wire iprc_levels_t levels,
  input  wire logic [10:0]  src_enabled,
  output logic      [2:0]   top_level,
  output logic      [3:0]   n_enabled
);
  // pick the highest level among enabled sources; purely combinational
  // so a new field value is seen at once
  always_comb begin
    top_level = 3'h0;
    n_enabled = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (src_enabled[i] && levels[i*3+:3] != 3'h0) begin // code 000 never requests
        n_enabled = n_enabled + 4'h1;
        if (levels[i*3+:3] > top_level) begin // 111 wins as level 7, 001 is lowest
          top_level = levels[i*3+:3];
        end
      end
    end
  end
endmodule : iprc_arb_model

// ===== verif/testbench.sv
// self-checking bench for the priority register block
// assumes: apb master driven here, arbiter model on the level outputs
`timescale 1ns/1ps
`include "iprc_consts.svh"
module testbench
  import iprc_pkg::*;
;
  logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [3:0]   pstrb;
  iprc_levels_t levels;
  logic [10:0]  src_enabled;
  logic [2:0]   top_level;
  logic [3:0]   n_enabled;
  logic [11:0]  ofs [5];
  logic [15:0]  msk [5];
  int           n_fail, comparisons;

  iprc_regs #(.NSRC(11)) i_iprc_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .levels(levels),
    .src_enabled(src_enabled));
  iprc_arb_model i_iprc_arb_model (.levels(levels), .src_enabled(src_enabled),
    .top_level(top_level), .n_enabled(n_enabled));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; bus released after the answer, one idle edge before the next
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) n_fail++;
    if (k >= 16) give_verdict();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // expected view of the arbiter side when every field holds code c
  task automatic lvl_chk(input logic [2:0] c);
    chk(levels, {11{c}});
    chk(src_enabled, {11{|c}});
    chk(top_level, c);
    chk(n_enabled, (|c) ? 4'hB : 4'h0);
  endtask : lvl_chk

  // apb leaves the bus idle, so reset never lands inside a transfer
  task automatic do_reset();
    logic [31:0] r;
    logic        e;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 16'h0000, r, e);
      chk(r, {17'h0, 16'h4444 & msk[i]});
    end
    lvl_chk(3'h4);
  endtask : do_reset

  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] pat;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
    ofs = '{`IPRC_OFS_PIN_CHANGE, `IPRC_OFS_CMP_1_3, `IPRC_OFS_CMP_4,
            `IPRC_OFS_ADC_0_2, `IPRC_OFS_ADC_3_5};
    msk = '{16'h7000, 16'h7770, 16'h0007, 16'h7770, 16'h0777};
    do_reset();
    // every code in every field, with bit 3 of each nibble set in the write data
    for (int c = 0; c < 8; c++) begin
      pat = 16'(16'h1111 * c) | 16'h8888;
      for (int i = 0; i < 5; i++) apb(1'b1, ofs[i], pat, r, e);
      for (int i = 0; i < 5; i++) begin
        apb(1'b0, ofs[i], 16'h0000, r, e);
        chk(r, {17'h0, pat & msk[i]});
        chk(e, 1'b0);
      end
      lvl_chk(3'(c));
    end
    // unmapped place: refused, reads zero, leaves fields alone
    apb(1'b1, 12'h0C4, 16'hFFFF, r, e);
    apb(1'b0, 12'h0C4, 16'h0000, r, e);
    chk(r, 33'h0);
    chk(e, 1'b1);
    apb(1'b0, ofs[0], 16'h0000, r, e);
    chk(r, {17'h0, 16'h7000});
    do_reset();
    // low lane only: adc pair 0 cleared, pairs 1 and 2 keep level 4
    pstrb <= 4'h1;
    apb(1'b1, ofs[3], 16'h0000, r, e);
    pstrb <= 4'hF;
    apb(1'b0, ofs[3], 16'h0000, r, e);
    chk(r, {17'h0, 16'h4400});
    chk(src_enabled, 11'h7DF);
    chk(n_enabled, 4'hA);
    give_verdict();
  end
endmodule : testbench
